// ==== design/pcla_line_access.v ====
// Software access path into a 16-line prefetch cache: tags, masks,
// data words, hit detection and replacement state.
// Assumes a synchronous register port and a fetch port on clk.
`timescale 1ns/100ps
`default_nettype none
`include "pcla_consts.vh"

module pcla_line_access #(
   parameter LINES = 16
) (
   input  wire        clk,
   input  wire        sys_rst,
   // Register port
   input  wire [5:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Level from configuration logic
   input  wire        code_protect,
   // Fetch port
   input  wire        fetch_vld,
   input  wire [23:0] fetch_addr,
   output reg         fetch_hit,
   output reg  [31:0] fetch_data,
   // Line fill from flash
   input  wire        fill_vld,
   input  wire [23:0] fill_addr,
   input  wire [127:0] fill_data,
   output wire [3:0]  fill_line
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg  [31:0]  data_mem [0:LINES*4-1];
   reg  [31:0]  tag_ff   [0:LINES-1];
   reg  [15:5]  mask_ff  [0:LINES-1];
   reg          wen_ff;
   reg  [3:0]   idx_ff;
   wire [24:0]  lru_state;
   wire [15:0]  locked;
   reg  [15:0]  hit_vec;
   reg  [3:0]   hit_line;
   reg          any_hit;
   integer      n;
   genvar       gi;

   // Register decode function, used by read and write paths
   function is_word;
      input [5:0] a;
      begin
         is_word = (a == `PCLA_OFS_WORD0) || (a == `PCLA_OFS_WORD1) ||
                   (a == `PCLA_OFS_WORD2) || (a == `PCLA_OFS_WORD3);
      end
   endfunction

   function [1:0] word_sel;
      input [5:0] a;
      reg   [5:0] ofs;
      begin
         ofs      = a - `PCLA_OFS_WORD0;
         word_sel = ofs[3:2];
      end
   endfunction

   wire line_wr = reg_wr & wen_ff;
   wire mask_ok = (idx_ff == `PCLA_MASK_LINE_A) ||
                  (idx_ff == `PCLA_MASK_LINE_B);

   // ----------------------------------------------------------------
   // Access control register
   // ----------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wen_ff <= 1'b0;
         idx_ff <= 4'h0;
      end else if (reg_wr && reg_addr == `PCLA_OFS_ACCESS) begin
         wen_ff <= reg_wdata[`PCLA_WEN_BIT];
         idx_ff <= reg_wdata[`PCLA_IDX_HI:0];
      end
   end

   // ----------------------------------------------------------------
   // Tag and mask per line
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < LINES; gi = gi + 1) begin : g_line
         always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               tag_ff[gi]  <= `PCLA_TAG_RESET;
               mask_ff[gi] <= 11'h000;
            end else begin
               if (line_wr && idx_ff == gi &&
                   reg_addr == `PCLA_OFS_TAG)
                  tag_ff[gi] <= reg_wdata & `PCLA_TAG_WMASK;
               else if (fill_vld && fill_line == gi)
                  tag_ff[gi] <= {1'b0, 7'h00,
                     fill_addr[`PCLA_TAG_HI:`PCLA_TAG_LO],
                     1'b1, tag_ff[gi][`PCLA_LOCK_BIT], 2'h2};
               // Mask only on lines A and B; bits 4..0 dropped
               if (line_wr && idx_ff == gi && mask_ok &&
                   reg_addr == `PCLA_OFS_MASK)
                  mask_ff[gi] <= reg_wdata[`PCLA_MASK_HI:`PCLA_MASK_LO];
            end
         end
         assign locked[gi] = tag_ff[gi][`PCLA_VALID_BIT] &
                             tag_ff[gi][`PCLA_LOCK_BIT];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Data array: words written in place, fills load whole lines except in a cycle with a word write
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (line_wr && is_word(reg_addr))
         data_mem[{idx_ff, word_sel(reg_addr)}] <= reg_wdata;
      else if (fill_vld) begin
         data_mem[{fill_line, 2'h0}] <= fill_data[31:0];
         data_mem[{fill_line, 2'h1}] <= fill_data[63:32];
         data_mem[{fill_line, 2'h2}] <= fill_data[95:64];
         data_mem[{fill_line, 2'h3}] <= fill_data[127:96];
      end
   end

   // ----------------------------------------------------------------
   // Hit detection with mask override
   // ----------------------------------------------------------------
   always @* begin
      hit_line = 4'h0;
      for (n = 0; n < LINES; n = n + 1) begin
         // Masked positions match regardless of tag
         hit_vec[n] = tag_ff[n][`PCLA_VALID_BIT] &&
            (((tag_ff[n][`PCLA_TAG_HI:`PCLA_TAG_LO] ^
               fetch_addr[`PCLA_TAG_HI:`PCLA_TAG_LO]) &
              ~{8'h00, mask_ff[n], 1'b0}) == 20'h00000);
         if (hit_vec[n])
            hit_line = n[3:0];
      end
      any_hit = fetch_vld & (|hit_vec);
   end

   // Fetch answer registered one cycle after request
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fetch_hit  <= 1'b0;
         fetch_data <= `PCLA_ZERO32;
      end else begin
         fetch_hit  <= any_hit;
         fetch_data <= any_hit ?
            data_mem[{hit_line, fetch_addr[3:2]}] : `PCLA_ZERO32;
      end
   end

   // ----------------------------------------------------------------
   // Replacement state, touched on fills and on hits in cycles without a fill
   // ----------------------------------------------------------------
   pcla_plru u_plru (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .touch_vld  (any_hit | fill_vld),
      .touch_line (fill_vld ? fill_line : hit_line),
      .locked     (locked),
      .state      (lru_state),
      .victim     (fill_line)
   );

   // ----------------------------------------------------------------
   // Read path, data in the cycle after the strobe
   // ----------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= `PCLA_ZERO32;
      else if (reg_rd) begin
         if (is_word(reg_addr))
            // Protected parts read zero
            reg_rdata <= code_protect ? `PCLA_ZERO32 :
               data_mem[{idx_ff, word_sel(reg_addr)}];
         else
            case (reg_addr)
               `PCLA_OFS_ACCESS: reg_rdata <= {wen_ff, 27'h0, idx_ff};
               `PCLA_OFS_TAG:    reg_rdata <= tag_ff[idx_ff];
               `PCLA_OFS_MASK:   reg_rdata <= {16'h0000, mask_ff[idx_ff],
                                               5'h00};
               `PCLA_OFS_LRU:    reg_rdata <= {7'h00, lru_state};
               default:          reg_rdata <= `PCLA_ZERO32;
            endcase
      end else
         reg_rdata <= `PCLA_ZERO32;
   end
endmodule // pcla_line_access
`default_nettype wire

// ==== design/pcla_consts.vh ====
// Constants for the prefetch cache line access block.
// Assumes inclusion by bare name from the design files.
`ifndef PCLA_CONSTS_VH
`define PCLA_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------
`define PCLA_OFS_ACCESS   6'h00
`define PCLA_OFS_TAG      6'h04
`define PCLA_OFS_MASK     6'h08
`define PCLA_OFS_WORD0    6'h0C
`define PCLA_OFS_WORD1    6'h10
`define PCLA_OFS_WORD2    6'h14
`define PCLA_OFS_WORD3    6'h18
`define PCLA_OFS_LRU      6'h1C

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define PCLA_WEN_BIT      31
`define PCLA_IDX_HI       3
`define PCLA_MASK_HI      15
`define PCLA_MASK_LO      5
`define PCLA_TAG_HI       23
`define PCLA_TAG_LO       4
`define PCLA_VALID_BIT    3
`define PCLA_LOCK_BIT     2
`define PCLA_TYPE_BIT     1
`define PCLA_BOOT_BIT     31
`define PCLA_LRU_W        25
`define PCLA_MASK_LINE_A  4'hA
`define PCLA_MASK_LINE_B  4'hB
`define PCLA_TAG_RESET    32'h00000002
`define PCLA_TAG_WMASK    32'h80FFFFFE
`define PCLA_ZERO32       32'h00000000

`endif

// ==== design/pcla_plru.v ====
// Pseudo-LRU tree over 16 lines in groups of four.
// Assumes a 4-bit touch line index from the cache, one line per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "pcla_consts.vh"

module pcla_plru (
   input  wire                  clk,
   input  wire                  sys_rst,
   input  wire                  touch_vld,
   input  wire [3:0]            touch_line,
   input  wire [15:0]           locked,
   output wire [`PCLA_LRU_W-1:0] state,
   output wire [3:0]            victim
);
   // State layout: [24:19] group pair order, [14:0] per group, [18:15] unused
   // group order: 6 pair bits (g0<g1,g0<g2,g0<g3,g1<g2,g1<g3,g2<g3)
   // per group: 3 tree bits from bit 4*group, group 3 also uses 3 bits
   reg  [`PCLA_LRU_W-1:0] state_ff;
   reg  [`PCLA_LRU_W-1:0] nxt_state;
   reg  [3:0]             victim_r;
   reg  [1:0]             grp;
   reg  [1:0]             sub;
   reg  [1:0]             v_grp;
   reg  [1:0]             v_sub;
   reg                    v_old;
   integer                g;
   integer                vi;
   integer                vj;

   // --------------------------------------------------------------
   // Pair-bit index among the six group-order bits
   // --------------------------------------------------------------
   function [2:0] pair_idx;
      input [1:0] a;
      input [1:0] b;
      begin
         case ({a, b})
            4'h1:    pair_idx = 3'h0;
            4'h2:    pair_idx = 3'h1;
            4'h3:    pair_idx = 3'h2;
            4'h6:    pair_idx = 3'h3;
            4'h7:    pair_idx = 3'h4;
            default: pair_idx = 3'h5;
         endcase
      end
   endfunction

   // Update: touched group and line become most recent
   always @* begin
      nxt_state = state_ff;
      grp = touch_line[3:2];
      sub = touch_line[1:0];
      if (touch_vld) begin
         for (g = 0; g < 4; g = g + 1) begin
            if (g[1:0] < grp)
               nxt_state[19 + pair_idx(g[1:0], grp)] = 1'b1;
            else if (g[1:0] > grp)
               nxt_state[19 + pair_idx(grp, g[1:0])] = 1'b0;
         end
         // Tree per group: bit0 picks half, bit1/bit2 pick line
         nxt_state[grp * 4 + 0] = ~sub[1];
         if (sub[1])
            nxt_state[grp * 4 + 2] = ~sub[0];
         else
            nxt_state[grp * 4 + 1] = ~sub[0];
      end
   end

   // Victim: group older than all others, then tree; a locked pick moves to its sibling line
   always @* begin
      v_grp = 2'h0;
      v_old = 1'b0;
      for (vi = 0; vi < 4; vi = vi + 1) begin
         v_old = 1'b1;
         for (vj = 0; vj < 4; vj = vj + 1) begin
            if (vj < vi)
               v_old = v_old & ~state_ff[19 + pair_idx(vj[1:0], vi[1:0])];
            else if (vj > vi)
               v_old = v_old & state_ff[19 + pair_idx(vi[1:0], vj[1:0])];
         end
         if (v_old)
            v_grp = vi[1:0];
      end
      v_sub[1] = state_ff[v_grp * 4 + 0];
      v_sub[0] = v_sub[1] ? state_ff[v_grp * 4 + 2] :
                            state_ff[v_grp * 4 + 1];
      victim_r = {v_grp, v_sub};
      if (locked[victim_r])
         victim_r = {v_grp, v_sub ^ 2'h1};
   end

   // State register, clear at power-on
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         state_ff <= {`PCLA_LRU_W{1'b0}};
      else
         state_ff <= nxt_state;
   end

   assign state  = state_ff;
   assign victim = victim_r;
endmodule // pcla_plru
`default_nettype wire

// ==== sim/pcla_line_access_sva.sv ====
// Checker on the ports of the line access block.
// Assumes the constants header on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "pcla_consts.vh"
module pcla_line_access_chk #(
   parameter LINES = 16
) (
   input wire logic         clk,
   input wire logic         sys_rst,
   input wire logic [5:0]   reg_addr,
   input wire logic [31:0]  reg_wdata,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [31:0]  reg_rdata,
   input wire logic         code_protect,
   input wire logic         fetch_vld,
   input wire logic [23:0]  fetch_addr,
   input wire logic         fetch_hit,
   input wire logic [31:0]  fetch_data,
   input wire logic         fill_vld,
   input wire logic [23:0]  fill_addr,
   input wire logic [127:0] fill_data,
   input wire logic [3:0]   fill_line
);
   // ------------------------------------------------------------
   // Helper logic and assertions
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic touched_ff;
   // Any fetch or fill since reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         touched_ff <= 1'b0;
      else if (fill_vld || fetch_vld)
         touched_ff <= 1'b1;
   end
   rd_idle_zero_a: assert property (
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside read");
   word_protect_a: assert property (
      reg_rd && code_protect && reg_addr >= `PCLA_OFS_WORD0 &&
      reg_addr <= `PCLA_OFS_WORD3 |=> reg_rdata == 32'h00000000)
      else $error("protected word read exposed data");
   lru_upper_a: assert property (
      reg_rd && reg_addr == `PCLA_OFS_LRU |=> reg_rdata[31:25] == 7'h00)
      else $error("state upper bits not zero");
   lru_reset_a: assert property (
      reg_rd && reg_addr == `PCLA_OFS_LRU && !touched_ff && !fill_vld &&
      !fetch_vld |=> reg_rdata == 32'h00000000)
      else $error("state not zero after reset");
   mask_unused_a: assert property (
      reg_rd && reg_addr == `PCLA_OFS_MASK |=>
      reg_rdata[31:16] == 16'h0000 && reg_rdata[4:0] == 5'h00)
      else $error("mask unused bits not zero");
   access_rsvd_a: assert property (
      reg_rd && reg_addr == `PCLA_OFS_ACCESS |=> reg_rdata[30:4] == 27'h0)
      else $error("access unused bits not zero");
   hit_cause_a: assert property (
      fetch_hit |-> $past(fetch_vld))
      else $error("hit without fetch");
   miss_data_a: assert property (
      fetch_vld |=> fetch_hit || fetch_data == 32'h00000000)
      else $error("miss data not zero");
   fill_hit_a: assert property (
      fill_vld ##2 (fetch_vld && fetch_addr[23:4] ==
      $past(fill_addr[23:4], 2)) |=> fetch_hit)
      else $error("filled line missed");
   cover property (fetch_hit);
   cover property (fill_vld);
   cover property (reg_rd && code_protect);
endmodule // pcla_line_access_chk
bind pcla_line_access pcla_line_access_chk #(.LINES(LINES)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .code_protect(code_protect),
   .fetch_vld(fetch_vld), .fetch_addr(fetch_addr),
   .fetch_hit(fetch_hit), .fetch_data(fetch_data),
   .fill_vld(fill_vld), .fill_addr(fill_addr),
   .fill_data(fill_data), .fill_line(fill_line));
`default_nettype wire

// ==== sim/pcla_core_model.sv ====
// Processor core model issuing one fetch per request.
// Assumes the answer stands in the cycle after the fetch.
`timescale 1ns/100ps
`default_nettype none
module pcla_core_model (
   input wire logic         clk,
   input wire logic         sys_rst,
   input wire logic         req,
   input wire logic [23:0]  req_addr,
   output var logic         fetch_vld,
   output var logic [23:0]  fetch_addr,
   input wire logic         fetch_hit,
   input wire logic [31:0]  fetch_data,
   output var logic         got_hit,
   output var logic [31:0]  got_data
);
   logic pend_ff;
   // Fetch launch, idle address toggles, answer capture
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fetch_vld  <= 1'b0;
         fetch_addr <= 24'h000000;
         pend_ff    <= 1'b0;
         got_hit    <= 1'b0;
         got_data   <= 32'h00000000;
      end else begin
         fetch_vld  <= req;
         fetch_addr <= req ? req_addr : ~fetch_addr;
         pend_ff    <= fetch_vld;
         if (pend_ff) begin
            got_hit  <= fetch_hit;
            got_data <= fetch_data;
         end
      end
   end
endmodule // pcla_core_model
`default_nettype wire

// ==== sim/pcla_line_access_bench.sv ====
// Self-checking bench for the line access block.
// Assumes the checker is bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "pcla_consts.vh"
module pcla_line_access_bench;
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic [5:0]   reg_addr = 6'h00;
   logic [31:0]  reg_wdata = 32'h00000000;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [31:0]  reg_rdata;
   logic         code_protect = 1'b0;
   logic         fetch_vld, fetch_hit, got_hit, req = 1'b0;
   logic [23:0]  fetch_addr, req_addr = 24'h000000;
   logic [31:0]  fetch_data, got_data, w [8], lru0, lru1;
   logic         fill_vld = 1'b0;
   logic [23:0]  fill_addr = 24'h000000;
   logic [127:0] fill_data = 128'h0;
   logic [3:0]   fill_line, fl;
   logic [23:0]  fa;
   logic [127:0] fd;
   integer       seed = 32'h1D53;
   integer       mismatches = 0;
   integer       checks = 0;
   localparam logic [23:0] TA = 24'h0ABC40;
   localparam logic [23:0] TM = 24'h3C0000;
   always #20 clk = ~clk;
   pcla_line_access #(.LINES(16)) dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .code_protect(code_protect), .fetch_vld(fetch_vld),
      .fetch_addr(fetch_addr), .fetch_hit(fetch_hit),
      .fetch_data(fetch_data), .fill_vld(fill_vld),
      .fill_addr(fill_addr), .fill_data(fill_data),
      .fill_line(fill_line));
   pcla_core_model core (.clk(clk), .sys_rst(sys_rst), .req(req),
      .req_addr(req_addr), .fetch_vld(fetch_vld),
      .fetch_addr(fetch_addr), .fetch_hit(fetch_hit),
      .fetch_data(fetch_data), .got_hit(got_hit), .got_data(got_data));
   // ------------------------------------------------------------
   // Bus, fetch and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] e,
                     input string n);
      logic [31:0] d;
      rd(a, d);
      chk(n, e, d);
   endtask
   task automatic fc(input logic [23:0] a, input logic h,
                     input logic [31:0] e);
      @(posedge clk);
      req      <= 1'b1;
      req_addr <= a;
      fill_vld <= 1'b0;   // A pending fill ends at the fetch launch
      @(posedge clk);
      req      <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("fetch_hit", {31'h0, h}, {31'h0, got_hit});
      chk("fetch_data", e, got_data);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rc(`PCLA_OFS_LRU, 32'h00000000, "lru_reset");
      rc(6'h20, 32'h00000000, "unmapped");
      wr(`PCLA_OFS_ACCESS, 32'h8000000A);
      wr(`PCLA_OFS_MASK, 32'hFFFFFFFF);
      rc(`PCLA_OFS_MASK, 32'h0000FFE0, "mask_a");
      wr(`PCLA_OFS_ACCESS, 32'h8000000B);
      rc(`PCLA_OFS_MASK, 32'h00000000, "mask_b");
      wr(`PCLA_OFS_ACCESS, 32'h80000003);
      wr(`PCLA_OFS_MASK, 32'hFFFFFFFF);
      rc(`PCLA_OFS_MASK, 32'h00000000, "mask_3");
      for (int i = 0; i < 8; i++) w[i] = $random(seed);
      for (int l = 0; l < 2; l++) begin
         wr(`PCLA_OFS_ACCESS, 32'h80000005 + l);
         for (int k = 0; k < 4; k++) wr(6'h0C + 6'(4 * k), w[4 * l + k]);
      end
      for (int k = 0; k < 4; k++) rc(6'h0C + 6'(4 * k), w[4 + k], "w6");
      wr(`PCLA_OFS_ACCESS, 32'h00000005);
      wr(`PCLA_OFS_WORD0, ~w[0]);
      for (int k = 0; k < 4; k++) rc(6'h0C + 6'(4 * k), w[k], "w5");
      @(posedge clk);
      code_protect <= 1'b1;
      rc(`PCLA_OFS_WORD1, 32'h00000000, "protect");
      @(posedge clk);
      code_protect <= 1'b0;
      wr(`PCLA_OFS_ACCESS, 32'h80000005);
      wr(`PCLA_OFS_TAG, {8'h00, TA[23:4], 4'hA});
      rd(`PCLA_OFS_LRU, lru0);
      fc(TA | 24'h8, 1'b1, w[2]);
      rd(`PCLA_OFS_LRU, lru1);
      chk("lru_moved", 32'h1, {31'h0, lru0 !== lru1});
      wr(`PCLA_OFS_WORD2, w[7]);
      fc(TA | 24'h8, 1'b1, w[7]);
      fl = fill_line;
      chk("victim_fresh", 32'h1, {31'h0, fl != 4'h5});
      fa = 24'($random(seed)) & 24'h7FFFF0;
      fd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge clk);
      fill_addr <= fa;
      fill_data <= fd;
      fill_vld  <= 1'b1;
      fc(fa | 24'hC, 1'b1, fd[127:96]);
      wr(`PCLA_OFS_ACCESS, {28'h0, fl});
      rc(`PCLA_OFS_WORD1, fd[63:32], "fill_word");
      wr(`PCLA_OFS_ACCESS, 32'h8000000A);
      wr(`PCLA_OFS_TAG, {8'h00, TM[23:4], 4'hA});
      wr(`PCLA_OFS_WORD0, w[1]);
      wr(`PCLA_OFS_MASK, 32'h00000020);
      fc(TM ^ 24'h20, 1'b1, w[1]);
      fc(TM ^ 24'h10, 1'b0, 32'h00000000);
      wr(`PCLA_OFS_MASK, 32'h00000000);
      fc(TM ^ 24'h20, 1'b0, 32'h00000000);
      finish_test;
   end
   // Watchdog against a hang
   initial begin
      #(40 * 5000);
      mismatches++;
      finish_test;
   end
endmodule // pcla_line_access_bench
`default_nettype wire
